// ===== clc_logic_cells.sv
// module: four configurable logic cells with their register file and edge flags
`timescale 1ns/1ns
`default_nettype none

module clc_logic_cells (
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              arst_n,
  // special function register port
  input  wire clc_pkg::clc_sfr_req_t             sfr_req,
  output logic [7:0]                             sfr_rdata,
  // external sources, one group per cell
  input  wire clc_pkg::clc_cell_src_t [3:0]      cell_src,
  // pins and status
  output logic [3:0]                             pin_out,
  output logic [3:0]                             pin_oe,
  output logic [3:0]                             level_out,
  output logic                                   irq
);

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [3:0][7:0]                 mx_reg;
  logic [3:0][7:0]                 fn_reg;
  logic [3:0][7:0]                 cf_reg;
  logic [3:0]                      en_reg;
  logic [7:0]                      ie_reg;
  logic [7:0]                      flags_reg;
  logic [7:0]                      flags_next;
  logic [3:0]                      flop_rst_reg;
  logic [3:0]                      flop_reg;
  logic [3:0]                      clk_q_reg;
  logic [3:0]                      level_reg;
  logic [3:0]                      prev_reg;
  logic [7:0]                      rdata_reg;
  logic [7:0]                      rdata_next;
  logic                            irq_reg;
  clc_pkg::clc_cell_src_t [3:0]    src_meta_reg;
  clc_pkg::clc_cell_src_t [3:0]    src_sync_reg;
  logic [3:0]                      lut_out;
  logic [3:0]                      cell_async;
  logic [3:0]                      a_in;
  logic [3:0]                      b_in;
  logic [3:0]                      sel_clk;
  logic [3:0]                      rise;
  logic [3:0]                      fall;

  ////////////////////////////////////////////////////////////////////////////////
  // input synchronisers: pins and foreign sources pass two flops

  // the first stage may go metastable and is read only by the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      src_meta_reg <= '0;
      src_sync_reg <= '0;
    end else begin
      src_meta_reg <= cell_src;
      src_sync_reg <= src_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // per cell datapath and configuration registers

  genvar gi;
  generate
    for (gi = 0; gi < clc_pkg::NUM_CELLS; gi++) begin : g_cell
      // selector codes, carry, config write strobe and raw flop clock of this cell
      logic [3:0] a_code;
      logic [3:0] b_code;
      logic       carry;
      logic       wr_cfg;
      logic       clk_raw;

      // selector fields of the mux register
      assign a_code = mx_reg[gi][clc_pkg::A_SEL_MSB:clc_pkg::A_SEL_LSB];
      assign b_code = mx_reg[gi][clc_pkg::B_SEL_MSB:clc_pkg::B_SEL_LSB];
      // carry ring: cell 0 takes cell 3's lut; the lut outputs form a
      // combinational ring, so a table that feeds its own carry back
      // inverted oscillates, which software must avoid
      assign carry  = lut_out[(gi + 3) % 4];
      // a config write with FLOP_RST_BIT set also launches the flop reset pulse below
      assign wr_cfg = sfr_req.wr && (sfr_req.addr == clc_pkg::CONFIG_ADDR[gi]);

      // low codes pick a cell's asynchronous output, its own included, unused codes give 0
      always_comb begin
        if (a_code < clc_pkg::CELL_CODES) begin
          a_in[gi] = cell_async[a_code[1:0]];
        end else if (a_code < clc_pkg::CELL_CODES + clc_pkg::EXT_CODES) begin
          a_in[gi] = src_sync_reg[gi].a_ext[a_code[1:0]];
        end else begin
          a_in[gi] = 1'b0;
        end
        // b selection mirrors a with its own external set
        if (b_code < clc_pkg::CELL_CODES) begin
          b_in[gi] = cell_async[b_code[1:0]];
        end else if (b_code < clc_pkg::CELL_CODES + clc_pkg::EXT_CODES) begin
          b_in[gi] = src_sync_reg[gi].b_ext[b_code[1:0]];
        end else begin
          b_in[gi] = 1'b0;
        end
      end

      // lookup table: a is the high index bit, carry the low
      assign lut_out[gi] = fn_reg[gi][{a_in[gi], b_in[gi], carry}];

      // output choice, forced low while the cell is disabled
      assign cell_async[gi] = en_reg[gi] &
        (cf_reg[gi][clc_pkg::OUT_SEL_BIT] ? lut_out[gi] : flop_reg[gi]);

      // flop clock source
      always_comb begin
        case (clc_pkg::clc_clk_src_t'(cf_reg[gi][clc_pkg::CLK_SRC_MSB:clc_pkg::CLK_SRC_LSB]))
          clc_pkg::CLC_CLK_CARRY: clk_raw = carry;
          clc_pkg::CLC_CLK_A:     clk_raw = a_in[gi];
          clc_pkg::CLC_CLK_ALT0:  clk_raw = src_sync_reg[gi].alt0;
          clc_pkg::CLC_CLK_ALT1:  clk_raw = src_sync_reg[gi].alt1;
          default:                clk_raw = carry;
        endcase
      end

      // inversion after selection, so every source can be taken on its fall
      assign sel_clk[gi] = clk_raw ^ cf_reg[gi][clc_pkg::CLK_INV_BIT];

      // configuration registers; reserved bits are not stored
      // so they always read back as zero, whatever software wrote
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          mx_reg[gi] <= clc_pkg::INPUT_SELECT_RESET;
          fn_reg[gi] <= clc_pkg::TRUTH_TABLE_RESET;
          cf_reg[gi] <= clc_pkg::CONFIG_RESET;
        end else begin
          if (sfr_req.wr && (sfr_req.addr == clc_pkg::INPUT_SELECT_ADDR[gi])) begin
            mx_reg[gi] <= sfr_req.wdata;
          end
          if (sfr_req.wr && (sfr_req.addr == clc_pkg::TRUTH_TABLE_ADDR[gi])) begin
            fn_reg[gi] <= sfr_req.wdata;
          end
          if (wr_cfg) begin
            cf_reg[gi] <= sfr_req.wdata & clc_pkg::CONFIG_STORE_MASK;
          end
        end
      end

      // reset request lives one cycle only, so the flop is never held
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          flop_rst_reg[gi] <= 1'b0;
        end else begin
          flop_rst_reg[gi] <= wr_cfg && sfr_req.wdata[clc_pkg::FLOP_RST_BIT];
        end
      end

      // flop sampled on system clock; a source clock rise is the edge seen
      // between two samples, so clocks faster than half the system rate alias;
      // the reset pulse wins over a capture in the same cycle
      always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
          clk_q_reg[gi] <= 1'b0;
          flop_reg[gi]  <= 1'b0;
        end else begin
          clk_q_reg[gi] <= sel_clk[gi];
          if (flop_rst_reg[gi]) begin
            flop_reg[gi] <= 1'b0;
          end else if (sel_clk[gi] && !clk_q_reg[gi]) begin
            flop_reg[gi] <= lut_out[gi];
          end
        end
      end

      // edge detect on current against previous synchronised level
      assign rise[gi] = level_reg[gi] && !prev_reg[gi];
      assign fall[gi] = !level_reg[gi] && prev_reg[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // global enables

  // cell and interrupt enables; reserved enable bits are not stored
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      en_reg <= clc_pkg::CELL_ENABLE_RESET;
      ie_reg <= clc_pkg::IRQ_ENABLE_RESET;
    end else begin
      if (sfr_req.wr && (sfr_req.addr == clc_pkg::CELL_ENABLE_ADDR)) begin
        en_reg <= sfr_req.wdata[3:0];
      end
      if (sfr_req.wr && (sfr_req.addr == clc_pkg::IRQ_ENABLE_ADDR)) begin
        ie_reg <= sfr_req.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // synchronised levels and edge flags

  // level is already zero for a disabled cell, so disabling makes a fall
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      level_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else begin
      level_reg <= cell_async;
      prev_reg  <= level_reg;
    end
  end

  // software writes first, hardware sets last so an edge is never lost
  always_comb begin
    flags_next = flags_reg;
    if (sfr_req.wr && (sfr_req.addr == clc_pkg::EDGE_FLAG_ADDR)) begin
      flags_next = sfr_req.wdata;
    end
    if (sfr_req.bit_wr && (sfr_req.addr[7:3] == clc_pkg::EDGE_FLAG_ADDR[7:3])) begin
      flags_next[sfr_req.addr[2:0]] = sfr_req.bit_val;
    end
    // hardware sets come last, so an edge in the cycle of a clear still lands
    for (int i = 0; i < clc_pkg::NUM_CELLS; i++) begin
      if (rise[i]) begin
        flags_next[2 * i + 1] = 1'b1;
      end
      if (fall[i]) begin
        flags_next[2 * i] = 1'b1;
      end
    end
  end

  // flag register; the next value already holds clears and sets
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flags_reg <= clc_pkg::EDGE_FLAG_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  // interrupt request follows any enabled flag
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(flags_reg & ie_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register read, answered one cycle after the strobe

  // read mux: unmapped addresses and reserved bits read zero
  always_comb begin
    rdata_next = 8'h00;
    // per cell registers
    for (int i = 0; i < clc_pkg::NUM_CELLS; i++) begin
      if (sfr_req.addr == clc_pkg::INPUT_SELECT_ADDR[i]) begin
        rdata_next = mx_reg[i];
      end
      if (sfr_req.addr == clc_pkg::TRUTH_TABLE_ADDR[i]) begin
        rdata_next = fn_reg[i];
      end
      if (sfr_req.addr == clc_pkg::CONFIG_ADDR[i]) begin
        rdata_next = cf_reg[i];
      end
    end
    // registers shared by all cells
    case (sfr_req.addr)
      clc_pkg::CELL_ENABLE_ADDR:  rdata_next = {4'h0, en_reg};
      clc_pkg::IRQ_ENABLE_ADDR:   rdata_next = ie_reg;
      clc_pkg::OUTPUT_LEVEL_ADDR: rdata_next = {4'h0, level_reg};
      clc_pkg::EDGE_FLAG_ADDR:    rdata_next = flags_reg;
      default:                    rdata_next = rdata_next;
    endcase
  end

  // read data holds until the next read so software may take it late
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else if (sfr_req.rd) begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs; the pin path stays asynchronous by design so it can wake the core

  // read data, levels and irq leave straight from their registers
  assign sfr_rdata = rdata_reg;
  assign level_out = level_reg;
  assign irq       = irq_reg;
  assign pin_out   = cell_async;

  // pin drive enables come straight from the stored config bit
  always_comb begin
    for (int i = 0; i < clc_pkg::NUM_CELLS; i++) begin
      pin_oe[i] = cf_reg[i][clc_pkg::PIN_EN_BIT];
    end
  end

endmodule // clc_logic_cells

`default_nettype wire

// ===== clc_logic_cells_checker.sv
// checker: port-level assertions of the logic cell block
`timescale 1ns/1ns
`default_nettype none

module clc_logic_cells_checker (
  // clock and reset
  input wire logic                         clock,
  input wire logic                         arst_n,
  // register port
  input wire clc_pkg::clc_sfr_req_t        sfr_req,
  input wire logic [7:0]                   sfr_rdata,
  // sources, pins and status
  input wire clc_pkg::clc_cell_src_t [3:0] cell_src,
  input wire logic [3:0]                   pin_out,
  input wire logic [3:0]                   pin_oe,
  input wire logic [3:0]                   level_out,
  input wire logic                         irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // status and config read data, checked one cycle after the read strobe
  AST_STATUS_TOP: assert property (sfr_req.rd && sfr_req.addr == 8'hd9
    |=> sfr_rdata[7:4] == 4'h0) else $error("status upper bits not zero");
  AST_STATUS_LEVEL: assert property (sfr_req.rd && sfr_req.addr == 8'hd9
    |=> sfr_rdata[3:0] == $past(level_out)) else $error("status low bits differ from levels");
  AST_CFG_RSVD: assert property (sfr_req.rd && sfr_req.addr == 8'hb1
    |=> sfr_rdata[5:3] == 3'h0) else $error("config reset or reserved bit reads set");
  // write then read two cycles later gives back what was stored
  AST_MX_READBACK: assert property (sfr_req.wr && sfr_req.addr == 8'h84
    ##2 sfr_req.rd && sfr_req.addr == 8'h84 |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("input select read-back differs");
  AST_TT_READBACK: assert property (sfr_req.wr && sfr_req.addr == 8'had
    ##2 sfr_req.rd && sfr_req.addr == 8'had |=> sfr_rdata == $past(sfr_req.wdata, 3))
    else $error("truth table read-back differs");
  AST_CFG_READBACK: assert property (sfr_req.wr && sfr_req.addr == 8'hb1
    ##2 sfr_req.rd && sfr_req.addr == 8'hb1 |=> sfr_rdata == ($past(sfr_req.wdata, 3) & 8'hc7))
    else $error("config read-back differs");
  AST_OE_CELL0: assert property (sfr_req.wr && sfr_req.addr == 8'hb1
    |=> pin_oe[0] == $past(sfr_req.wdata[6])) else $error("pin enable does not follow config");
  // every level bit takes its cell output one edge later, on every edge
  AST_LEVEL_FOLLOW: assert property (level_out == $past(pin_out))
    else $error("level does not follow cell output");
endmodule // clc_logic_cells_checker

bind clc_logic_cells clc_logic_cells_checker i_chk (.clock(clock), .arst_n(arst_n),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .cell_src(cell_src), .pin_out(pin_out),
  .pin_oe(pin_oe), .level_out(level_out), .irq(irq));

`default_nettype wire

// ===== clc_logic_cells_test.sv
// testbench: register-level tests of the logic cell block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module clc_logic_cells_test;
  logic                         clock;
  logic                         arst_n;
  clc_pkg::clc_sfr_req_t        req;
  logic [7:0]                   rdata;
  clc_pkg::clc_cell_src_t [3:0] src;
  logic [3:0]                   pin_out;
  logic [3:0]                   pin_oe;
  logic [3:0]                   level_out;
  logic                         irq;
  logic [7:0]                   fns [2] = '{8'hc0, 8'h3c};
  int                           bad_count = 0;
  int                           tests_run = 0;
  int                           cyc = 0;

  clc_logic_cells i_dut (.clock(clock), .arst_n(arst_n), .sfr_req(req), .sfr_rdata(rdata),
    .cell_src(src), .pin_out(pin_out), .pin_oe(pin_oe), .level_out(level_out), .irq(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard; the tests need well under a thousand cycles
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      bad_count++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register access tasks, driven at the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    req.addr = a;
    req.wdata = d;
    req.wr = 1'b1;
    @(negedge clock);
    req.wr = 1'b0;
  endtask
  task automatic bwr(input logic [7:0] a, input logic b);
    @(negedge clock);
    req.addr = a;
    req.bit_val = b;
    req.bit_wr = 1'b1;
    @(negedge clock);
    req.bit_wr = 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input string nm);
    @(negedge clock);
    req.addr = a;
    req.rd = 1'b1;
    @(negedge clock);
    req.rd = 1'b0;
    `CHK(nm, exp, rdata)
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    req = '0;
    src = '0;
    arst_n = 1'b0;
    repeat (10) @(negedge clock);
    arst_n = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rchk(clc_pkg::INPUT_SELECT_ADDR[i], 8'h00, "mx reset");
      rchk(clc_pkg::TRUTH_TABLE_ADDR[i], 8'h00, "fn reset");
      rchk(clc_pkg::CONFIG_ADDR[i], 8'h00, "cf reset");
    end
    rchk(8'hd9, 8'h00, "level reset");
    rchk(8'he8, 8'h00, "flag reset");
    $display("test reset done");
    // access kinds: read-back, self-clearing bit, read-only status
    wr(8'h84, 8'h5a);
    rchk(8'h84, 8'h5a, "mx");
    wr(8'hb1, 8'hcf);
    rchk(8'hb1, 8'hc7, "cf");
    `CHK("oe", 4'h1, pin_oe)
    wr(8'hb1, 8'h00);
    wr(8'hd9, 8'h0f);
    rchk(8'hd9, 8'h00, "status");
    rchk(8'h00, 8'h00, "unmapped");
    $display("test access done");
    // lut on cell 0: and, then xor, driven from external a and b
    wr(8'hcb, 8'h01);
    wr(8'h84, 8'h44);
    wr(8'hb1, 8'hc0);
    foreach (fns[f]) for (int k = 0; k < 4; k++) begin
      wr(8'had, fns[f]);
      src[0].a_ext[0] = k[1];
      src[0].b_ext[0] = k[0];
      idle(4);
      `CHK("lut", fns[f][2*k], pin_out[0])
      rchk(8'hd9, {7'h00, fns[f][2*k]}, "level");
    end
    // both edges happened; irq on fall, then single-bit clear
    rchk(8'he8, 8'h03, "flags");
    wr(8'hcd, 8'h01);
    idle(2);
    `CHK("irq on", 1'b1, irq)
    bwr(8'he8, 1'b0);
    idle(2);
    `CHK("irq off", 1'b0, irq)
    rchk(8'he8, 8'h02, "bit clear");
    $display("test lut done");
    // carry from cell 3 into cell 0, which passes its carry
    wr(8'hcb, 8'h09);
    wr(8'h92, 8'hff);
    wr(8'hca, 8'hc0);
    wr(8'had, 8'haa);
    wr(8'hc7, 8'hff);
    idle(1);
    `CHK("carry hi", 4'h9, pin_out)
    wr(8'hc7, 8'h00);
    idle(1);
    `CHK("carry lo", 4'h0, pin_out)
    wr(8'he8, 8'h00);
    $display("test carry done");
    // flop: reset, then capture on a, alt0, alt1 and inverted a
    wr(8'hcb, 8'h01);
    wr(8'had, 8'hff);
    rchk(8'had, 8'hff, "fn");
    for (int c = 1; c < 5; c++) begin
      src[0].a_ext[0] = (c == 4);
      idle(3);
      wr(8'hb1, (c == 4) ? 8'h4d : (8'h48 | 8'(c)));
      idle(3);
      `CHK("flop reset", 1'b0, pin_out[0])
      src[0].a_ext[0] = (c == 1);
      src[0].alt0 = (c == 2);
      src[0].alt1 = (c == 3);
      idle(5);
      `CHK("flop capture", 1'b1, pin_out[0])
    end
    // carry as flop clock: reset, then raise cell 3's lut
    wr(8'hb1, 8'h48);
    idle(3);
    `CHK("carry reset", 1'b0, pin_out[0])
    wr(8'hc7, 8'hff);
    idle(2);
    `CHK("carry clock", 1'b1, pin_out[0])
    // disabling drops both outputs
    wr(8'hcb, 8'h00);
    idle(2);
    `CHK("off pin", 1'b0, pin_out[0])
    `CHK("off level", 1'b0, level_out[0])
    $display("test flop done");
    final_report();
  end
endmodule // clc_logic_cells_test

`default_nettype wire

// ===== clc_pkg.sv
// package: register map, field layout and carriers of the configurable logic cells
package clc_pkg;

  localparam int NUM_CELLS = 4;

  // special function register addresses, per cell ones with cell 3 first, then shared ones
  localparam logic [3:0][7:0] INPUT_SELECT_ADDR = {8'h92, 8'h91, 8'h85, 8'h84};
  localparam logic [3:0][7:0] TRUTH_TABLE_ADDR  = {8'hc7, 8'hbc, 8'hb9, 8'had};
  localparam logic [3:0][7:0] CONFIG_ADDR       = {8'hca, 8'hbd, 8'hbb, 8'hb1};
  localparam logic [7:0] CELL_ENABLE_ADDR  = 8'hcb;
  localparam logic [7:0] IRQ_ENABLE_ADDR   = 8'hcd;
  localparam logic [7:0] OUTPUT_LEVEL_ADDR = 8'hd9;
  localparam logic [7:0] EDGE_FLAG_ADDR    = 8'he8;

  // reset values
  localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
  localparam logic [7:0] TRUTH_TABLE_RESET  = 8'h00;
  localparam logic [7:0] CONFIG_RESET       = 8'h00;
  localparam logic [7:0] EDGE_FLAG_RESET    = 8'h00;
  localparam logic [3:0] CELL_ENABLE_RESET  = 4'h0;
  localparam logic [7:0] IRQ_ENABLE_RESET   = 8'h00;

  // field positions
  localparam int A_SEL_MSB        = 7;
  localparam int A_SEL_LSB        = 4;
  localparam int B_SEL_MSB        = 3;
  localparam int B_SEL_LSB        = 0;
  localparam int OUT_SEL_BIT      = 7;
  localparam int PIN_EN_BIT       = 6;
  localparam int FLOP_RST_BIT     = 3;
  localparam int CLK_INV_BIT      = 2;
  localparam int CLK_SRC_MSB      = 1;
  localparam int CLK_SRC_LSB      = 0;
  // config bits that hold state; reserved and self-clearing bits read 0
  localparam logic [7:0] CONFIG_STORE_MASK = 8'hc7;
  // number of selector codes that pick a cell's output, the selecting cell's own included
  localparam logic [3:0] CELL_CODES = 4'h4;
  localparam logic [3:0] EXT_CODES  = 4'h4;

  // flop clock source codes
  typedef enum logic [1:0] {
    CLC_CLK_CARRY = 2'b00,
    CLC_CLK_A     = 2'b01,
    CLC_CLK_ALT0  = 2'b10,
    CLC_CLK_ALT1  = 2'b11
  } clc_clk_src_t;

  // one special function register access from the core
  typedef struct packed {
    logic [7:0] addr;    // byte address, or bit address when bit_wr is set
    logic       wr;      // byte write strobe
    logic       rd;      // byte read strobe
    logic       bit_wr;  // single bit write strobe
    logic       bit_val; // value for a single bit write
    logic [7:0] wdata;   // byte write data
  } clc_sfr_req_t;

  // raw external sources of one cell
  typedef struct packed {
    logic [3:0] a_ext;   // a selector codes 4..7
    logic [3:0] b_ext;   // b selector codes 4..7
    logic       alt0;    // alternate clock zero
    logic       alt1;    // alternate clock one
  } clc_cell_src_t;

endpackage : clc_pkg
